// >>> design/mic_core.sv
`timescale 1ns/1ps
// What this block does
// - Nonmaskable request wins, ignores mask flag
// - Nonmaskable pin edge-sensed, edge bit picks polarity
// - Nonmaskable request uses vector three
// - External and nonmaskable requests wake software standby
// - Lines 0-2, 6 falling-edge or low-level each
// - Sense bit one edge, zero level
// - Line 6 ORs eight unmasked key inputs
// - Vectors 4-6 for lines 0-2, 10 for 6
// - Line 0 highest, line 6 lowest externally
// - Detection ignores pin direction
// - Twenty-six peripheral requests, enabled, masked by flag
// - Peripheral vectors 17-36 and 44-49
// - Maskable needs enable one and mask zero
// - Nonmaskable blocked in reset and hardware standby
// - Masked requests stay pending, not discarded
// - Highest accepted goes to CPU, others wait
// - CPU starts sequence at boundary, latches vector
// - Push PC and CONDITION_CODE_BYTE, set mask, fetch vector
// - CONDITION_CODE_BYTE doubled on stack; return restores even byte
// - Arbitration two states external, one internal
// - Request racing its disable still served unless outranked
module mic_core #(
	parameter int PERIPH_COUNT = mic_pkg::PERIPH_COUNT
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Pins from outside, asynchronous
	input wire logic nonmask_pin,
	input wire logic [2:0] ext_request_n,
	input wire logic [7:0] key_sense_input_n,
	// Configuration bits
	input wire mic_pkg::mic_cfg_type cfg,
	// On-chip peripheral requests and their module enables
	input wire logic [PERIPH_COUNT-1:0] periph_req,
	input wire logic [PERIPH_COUNT-1:0] periph_enable,
	// CPU state
	input wire logic global_mask,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic instr_done,
	input wire logic [15:0] cpu_pc,
	input wire logic [7:0] condition_code_byte,
	// Return from exception
	input wire logic return_from_exception,
	input wire logic [15:0] stack_word,
	// Request to the CPU
	output mic_pkg::mic_grant_type grant_reg,
	output logic wake_reg,
	// Exception sequence
	output logic seq_busy_reg,
	output logic stack_write_reg,
	output logic [15:0] stack_data_reg,
	output logic mask_set_reg,
	output logic vector_fetch_reg,
	output logic [15:0] vector_addr_reg,
	output logic [7:0] restored_ccr_reg
);
	// Synchroniser chain and filtered levels
	logic [mic_pkg::PIN_COUNT-1:0] pin_raw;
	logic [mic_pkg::PIN_COUNT-1:0] sync1_reg;
	logic [mic_pkg::PIN_COUNT-1:0] sync2_reg;
	logic [mic_pkg::PIN_COUNT-1:0] sync3_reg;
	logic [mic_pkg::PIN_COUNT-1:0] pin_level_reg;
	logic [mic_pkg::PIN_COUNT-1:0] agree;
	// External line view, bit 3 is line 6
	logic [3:0] ext_low;
	logic [3:0] ext_low_prev_reg;
	logic [3:0] ext_fall;
	logic [3:0] ext_en;
	logic [3:0] ext_edge_mode;
	logic [3:0] ext_latch_reg;
	logic [3:0] ext_req;
	logic [3:0] ext_stage_reg;
	logic [3:0] ext_ok;
	logic [3:0] ext_drop;
	// Nonmaskable path
	logic nonmask_prev_reg;
	logic nonmask_edge;
	logic nonmask_latch_reg;
	logic nonmask_stage_reg;
	logic nonmask_ok;
	// Peripheral path
	logic [PERIPH_COUNT-1:0] periph_ok;
	// Arbitration result
	mic_pkg::mic_grant_type grant_next;
	logic [3:0] win_ext_next;
	logic win_nonmask_next;
	logic [3:0] win_ext_reg;
	logic win_nonmask_reg;
	logic take;
	// Sequencer
	mic_pkg::mic_seq_type state_reg;
	mic_pkg::mic_seq_type state_next;
	logic [5:0] vec_hold_reg;
	logic [15:0] pc_hold_reg;
	logic [7:0] ccr_hold_reg;

	// Pin levels are used whatever the port direction is
	assign pin_raw = {key_sense_input_n, ext_request_n, nonmask_pin};

	// Three-stage synchroniser
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync1_reg <= mic_pkg::PIN_IDLE;
			sync2_reg <= mic_pkg::PIN_IDLE;
			sync3_reg <= mic_pkg::PIN_IDLE;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// A change counts only once stages two and three agree
	assign agree = ~(sync2_reg ^ sync3_reg);

	// Filtered pin level
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_level_reg <= mic_pkg::PIN_IDLE;
		end else begin
			pin_level_reg <= (agree & sync3_reg) | (~agree & pin_level_reg);
		end
	end

	// Active-low lines; line 6 is any unmasked key held low
	always_comb begin
		ext_low[2:0] = ~pin_level_reg[mic_pkg::PIN_EXT_LSB +: 3];
		ext_low[3] = |(~pin_level_reg[mic_pkg::PIN_KEY_LSB +: mic_pkg::KEY_COUNT]
			& ~cfg.key_mask_bits);
	end

	// Per-line enable and sense bits; lines 0 to 2 sit side by side
	assign ext_en = {cfg.request_enable_reg[mic_pkg::POS_LINE6],
		cfg.request_enable_reg[mic_pkg::POS_LINE2:mic_pkg::POS_LINE0]};
	assign ext_edge_mode = {cfg.sense_select_reg[mic_pkg::POS_LINE6],
		cfg.sense_select_reg[mic_pkg::POS_LINE2:mic_pkg::POS_LINE0]};

	// Previous levels for edge finding
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ext_low_prev_reg <= 4'h0;
			nonmask_prev_reg <= 1'b1;
		end else begin
			ext_low_prev_reg <= ext_low;
			nonmask_prev_reg <= pin_level_reg[mic_pkg::PIN_NONMASK];
		end
	end

	// Falling pin means a rising low-level flag
	assign ext_fall = ext_low & ~ext_low_prev_reg;

	// Edge select bit: one for rising, zero for falling
	assign nonmask_edge = cfg.nonmask_edge_select ?
		(pin_level_reg[mic_pkg::PIN_NONMASK] & ~nonmask_prev_reg) :
		(~pin_level_reg[mic_pkg::PIN_NONMASK] & nonmask_prev_reg);

	// Accepted by the CPU; a maskable winner registered before the mask rose waits
	assign take = (state_reg == mic_pkg::SEQ_IDLE) & instr_done & grant_reg.valid
		& (~global_mask | win_nonmask_reg);

	// Disabled pending lines outranked by the winner are dropped
	always_comb begin
		if (win_nonmask_reg) begin
			ext_drop = ~ext_en;
		end else begin
			ext_drop = ~ext_en & ~(win_ext_reg | (win_ext_reg - 4'h1));
		end
		if (~take || win_ext_reg == 4'h0 && !win_nonmask_reg) begin
			ext_drop = 4'h0;
		end
	end

	// Edge latches; a new edge wins over any clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ext_latch_reg <= 4'h0;
		end else begin
			for (int i = 0; i < mic_pkg::EXT_LINES; i++) begin
				if (ext_fall[i] && ext_edge_mode[i] && ext_en[i]) begin
					ext_latch_reg[i] <= 1'b1;
				end else if (take && win_ext_reg[i]) begin
					ext_latch_reg[i] <= 1'b0;
				end else if (ext_drop[i]) begin
					ext_latch_reg[i] <= 1'b0;
				end else if (global_mask && !ext_edge_mode[i] && !ext_en[i]) begin
					// Software flush: masked, level mode, disabled
					ext_latch_reg[i] <= 1'b0;
				end
			end
		end
	end

	// Edge lines come from the latch, level lines follow the pin live
	assign ext_req = (ext_latch_reg & ext_edge_mode)
		| (ext_low & ~ext_edge_mode & ext_en);

	// Nonmaskable latch, never armed in hardware standby
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			nonmask_latch_reg <= 1'b0;
		end else if (hw_standby) begin
			nonmask_latch_reg <= 1'b0;
		end else if (nonmask_edge) begin
			nonmask_latch_reg <= 1'b1;
		end else if (take && win_nonmask_reg) begin
			nonmask_latch_reg <= 1'b0;
		end
	end

	// Extra stage gives external sources their second arbitration state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ext_stage_reg <= 4'h0;
			nonmask_stage_reg <= 1'b0;
		end else begin
			ext_stage_reg <= ext_req;
			nonmask_stage_reg <= nonmask_latch_reg & ~hw_standby;
		end
	end

	// Acceptance: maskable ones wait while the mask flag is set
	always_comb begin
		ext_ok = ext_stage_reg & ext_req & {4{~global_mask}};
		nonmask_ok = nonmask_stage_reg & nonmask_latch_reg & ~hw_standby;
		periph_ok = periph_req & periph_enable & {PERIPH_COUNT{~global_mask}};
	end

	// Fixed priority: scan low to high so the highest overwrites
	always_comb begin
		grant_next = '0;
		win_ext_next = 4'h0;
		win_nonmask_next = 1'b0;
		for (int i = PERIPH_COUNT - 1; i >= 0; i--) begin
			if (periph_ok[i]) begin
				grant_next.valid = 1'b1;
				grant_next.vector = mic_pkg::periph_vector(i);
			end
		end
		if (ext_ok[3]) begin
			grant_next.valid = 1'b1;
			grant_next.vector = mic_pkg::VEC_EXT6;
			win_ext_next = 4'h8;
		end
		for (int i = 2; i >= 0; i--) begin
			if (ext_ok[i]) begin
				grant_next.valid = 1'b1;
				grant_next.vector = mic_pkg::VEC_EXT0 + 6'(i);
				win_ext_next = 4'(1 << i);
			end
		end
		if (nonmask_ok) begin
			grant_next.valid = 1'b1;
			grant_next.vector = mic_pkg::VEC_NONMASK;
			win_ext_next = 4'h0;
			win_nonmask_next = 1'b1;
		end
	end

	// Grant register; dropped for one cycle on acceptance so a stale
	// winner is never presented twice while its source clears
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			grant_reg <= '0;
			win_ext_reg <= 4'h0;
			win_nonmask_reg <= 1'b0;
		end else if (take) begin
			grant_reg <= '0;
			win_ext_reg <= 4'h0;
			win_nonmask_reg <= 1'b0;
		end else begin
			grant_reg <= grant_next;
			win_ext_reg <= win_ext_next;
			win_nonmask_reg <= win_nonmask_next;
		end
	end

	// Wake from software standby on any external or nonmaskable request
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= sw_standby & (nonmask_latch_reg | (|ext_req));
		end
	end

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			mic_pkg::SEQ_IDLE: begin
				if (take) begin
					state_next = mic_pkg::SEQ_PUSH_PC;
				end
			end
			mic_pkg::SEQ_PUSH_PC: state_next = mic_pkg::SEQ_PUSH_CCR;
			mic_pkg::SEQ_PUSH_CCR: state_next = mic_pkg::SEQ_SET_MASK;
			mic_pkg::SEQ_SET_MASK: state_next = mic_pkg::SEQ_FETCH;
			mic_pkg::SEQ_FETCH: state_next = mic_pkg::SEQ_IDLE;
			default: begin
				// Illegal code recovers to idle
				state_next = mic_pkg::SEQ_IDLE;
			end
		endcase
	end

	// Sequencer state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= mic_pkg::SEQ_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Vector, PC and CONDITION_CODE_BYTE caught at acceptance
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vec_hold_reg <= 6'h00;
			pc_hold_reg <= 16'h0000;
			ccr_hold_reg <= 8'h00;
		end else if (take) begin
			vec_hold_reg <= grant_reg.vector;
			pc_hold_reg <= cpu_pc;
			ccr_hold_reg <= condition_code_byte;
		end
	end

	// Sequence outputs, one cycle behind the state; busy comes from the next state, so it lines up with the state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			seq_busy_reg <= 1'b0;
			stack_write_reg <= 1'b0;
			stack_data_reg <= 16'h0000;
			mask_set_reg <= 1'b0;
			vector_fetch_reg <= 1'b0;
			vector_addr_reg <= 16'h0000;
		end else begin
			seq_busy_reg <= (state_next != mic_pkg::SEQ_IDLE);
			stack_write_reg <= (state_reg == mic_pkg::SEQ_PUSH_PC)
				| (state_reg == mic_pkg::SEQ_PUSH_CCR);
			if (state_reg == mic_pkg::SEQ_PUSH_CCR) begin
				stack_data_reg <= {ccr_hold_reg, ccr_hold_reg};
			end else begin
				stack_data_reg <= pc_hold_reg;
			end
			mask_set_reg <= (state_reg == mic_pkg::SEQ_SET_MASK);
			vector_fetch_reg <= (state_reg == mic_pkg::SEQ_FETCH);
			// Two-byte table entries
			vector_addr_reg <= {9'h000, vec_hold_reg, 1'b0};
		end
	end

	// Return takes the even-address byte, the odd copy is ignored
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			restored_ccr_reg <= 8'h00;
		end else if (return_from_exception) begin
			restored_ccr_reg <= stack_word[mic_pkg::EVEN_BYTE_MSB:mic_pkg::EVEN_BYTE_LSB];
		end
	end
endmodule : mic_core

// >>> design/mic_pkg.sv
package mic_pkg;
	// Source counts
	localparam int EXT_LINES = 4;
	localparam int KEY_COUNT = 8;
	localparam int PERIPH_COUNT = 26;
	localparam int PERIPH_LOW_COUNT = 20;
	localparam int PIN_COUNT = 1 + 3 + KEY_COUNT;
	// Vector numbers
	localparam logic [5:0] VEC_NONMASK = 6'h03;
	localparam logic [5:0] VEC_EXT0 = 6'h04;
	localparam logic [5:0] VEC_EXT6 = 6'h0A;
	localparam logic [5:0] VEC_PERIPH_LOW = 6'h11;
	localparam logic [5:0] VEC_PERIPH_HIGH = 6'h2C;
	// Field positions of the external lines in the 8-bit config bytes
	localparam int POS_LINE0 = 0;
	localparam int POS_LINE1 = 1;
	localparam int POS_LINE2 = 2;
	localparam int POS_LINE6 = 6;
	// Pin vector positions
	localparam int PIN_NONMASK = 0;
	localparam int PIN_EXT_LSB = 1;
	localparam int PIN_KEY_LSB = 4;
	// Reset values
	localparam logic [PIN_COUNT-1:0] PIN_IDLE = 12'hFFF;
	localparam logic [7:0] RESET_KEY_MASK = 8'hFF;
	localparam logic [7:0] RESET_SENSE = 8'hB8;
	localparam logic [7:0] RESET_ENABLE = 8'hB8;
	// Byte that a return restores: the even address is the high byte
	localparam int EVEN_BYTE_MSB = 15;
	localparam int EVEN_BYTE_LSB = 8;

	// Configuration bits
	typedef struct packed {
		logic nonmask_edge_select;
		logic [7:0] sense_select_reg;
		logic [7:0] request_enable_reg;
		logic [7:0] key_mask_bits;
	} mic_cfg_type;

	// Request handed to the CPU
	typedef struct packed {
		logic valid;
		logic [5:0] vector;
	} mic_grant_type;

	// Exception sequencer states
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'h0,
		SEQ_PUSH_PC = 3'h1,
		SEQ_PUSH_CCR = 3'h3,
		SEQ_SET_MASK = 3'h2,
		SEQ_FETCH = 3'h6
	} mic_seq_type;

	// Vector of a peripheral request by its index
	function automatic logic [5:0] periph_vector(input int idx);
		if (idx < PERIPH_LOW_COUNT) begin
			periph_vector = VEC_PERIPH_LOW + 6'(idx);
		end else begin
			periph_vector = VEC_PERIPH_HIGH + 6'(idx - PERIPH_LOW_COUNT);
		end
	endfunction : periph_vector
endpackage : mic_pkg

// >>> testbench/mic_core_checker.sv
`timescale 1ns/1ps
module mic_core_checker #(
	parameter int PERIPH_COUNT = mic_pkg::PERIPH_COUNT
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// CPU side inputs
	input wire logic instr_done,
	input wire logic global_mask,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic [15:0] cpu_pc,
	input wire logic [7:0] condition_code_byte,
	input wire logic return_from_exception,
	input wire logic [15:0] stack_word,
	// Controller outputs
	input wire mic_pkg::mic_grant_type grant_reg,
	input wire logic wake_reg,
	input wire logic seq_busy_reg,
	input wire logic stack_write_reg,
	input wire logic [15:0] stack_data_reg,
	input wire logic mask_set_reg,
	input wire logic vector_fetch_reg,
	input wire logic [15:0] vector_addr_reg,
	input wire logic [7:0] restored_ccr_reg
);
	// One domain only
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Two stacked words, one after the other
	sequence push_s;
		stack_write_reg ##1 stack_write_reg;
	endsequence
	// Mask then vector fetch
	sequence tail_s;
		mask_set_reg ##1 vector_fetch_reg;
	endsequence
	// A maskable winner is not taken once the mask is up
	accept_go_a: assert property (instr_done && grant_reg.valid && !seq_busy_reg
		&& (!global_mask || grant_reg.vector == mic_pkg::VEC_NONMASK)
		|=> $rose(seq_busy_reg) && !grant_reg.valid) else $error("acceptance did not start");
	mask_accept_a: assert property ($rose(seq_busy_reg) && $past(global_mask)
		|-> $past(grant_reg.vector) == mic_pkg::VEC_NONMASK)
		else $error("maskable accepted under mask");
	seq_order_a: assert property ($rose(seq_busy_reg) |=> push_s ##1 tail_s)
		else $error("sequence order wrong");
	busy_len_a: assert property ($rose(seq_busy_reg) |-> seq_busy_reg [*4] ##1 !seq_busy_reg)
		else $error("busy length wrong");
	pc_push_a: assert property ($rose(seq_busy_reg) |=> stack_data_reg == $past(cpu_pc, 2))
		else $error("pushed pc wrong");
	ccr_dup_a: assert property ($rose(seq_busy_reg) |-> ##2
		stack_data_reg == {2{$past(condition_code_byte, 3)}}) else $error("ccr word wrong");
	vec_addr_a: assert property ($rose(seq_busy_reg) |-> ##4
		vector_addr_reg == {9'h000, $past(grant_reg.vector, 5), 1'b0}) else $error("addr wrong");
	ccr_restore_a: assert property (return_from_exception |=>
		restored_ccr_reg == $past(stack_word[15:8])) else $error("restored ccr wrong");
	mask_only_nm_a: assert property (global_mask && $past(global_mask) && $past(global_mask, 2)
		&& grant_reg.valid |-> grant_reg.vector == mic_pkg::VEC_NONMASK)
		else $error("maskable granted under mask");
	hw_block_a: assert property (hw_standby && $past(hw_standby) && $past(hw_standby, 2)
		|-> !(grant_reg.valid && grant_reg.vector == mic_pkg::VEC_NONMASK))
		else $error("nonmask in hw standby");
	wake_off_a: assert property (!sw_standby |=> !wake_reg) else $error("wake without standby");
endmodule : mic_core_checker

bind mic_core mic_core_checker #(.PERIPH_COUNT(PERIPH_COUNT)) mic_chk (
	.clock(clock),
	.rst(rst),
	.instr_done(instr_done),
	.global_mask(global_mask),
	.hw_standby(hw_standby),
	.sw_standby(sw_standby),
	.cpu_pc(cpu_pc),
	.condition_code_byte(condition_code_byte),
	.return_from_exception(return_from_exception),
	.stack_word(stack_word),
	.grant_reg(grant_reg),
	.wake_reg(wake_reg),
	.seq_busy_reg(seq_busy_reg),
	.stack_write_reg(stack_write_reg),
	.stack_data_reg(stack_data_reg),
	.mask_set_reg(mask_set_reg),
	.vector_fetch_reg(vector_fetch_reg),
	.vector_addr_reg(vector_addr_reg),
	.restored_ccr_reg(restored_ccr_reg)
);

// >>> testbench/mic_cpu_model.sv
`timescale 1ns/1ps
module mic_cpu_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Controller side
	input wire logic mask_set_reg,
	output logic instr_done,
	output logic global_mask,
	// Bench control
	input wire logic slow,
	input wire logic mask_load,
	input wire logic mask_value
);
	// Boundary every cycle unless a long instruction is modelled
	assign instr_done = !slow;
	// Mask flag: the sequence sets it, software loads win otherwise
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			global_mask <= 1'b0;
		end else if (mask_set_reg) begin
			global_mask <= 1'b1;
		end else if (mask_load) begin
			global_mask <= mask_value;
		end
	end
endmodule : mic_cpu_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	// Design and model signals
	logic clock, rst, nonmask_pin, hw_standby, sw_standby, instr_done, global_mask;
	logic [2:0] ext_request_n;
	logic [7:0] key_sense_input_n, condition_code_byte, restored_ccr_reg;
	mic_pkg::mic_cfg_type cfg;
	logic [25:0] periph_req, periph_enable;
	logic [15:0] cpu_pc, stack_word, stack_data_reg, vector_addr_reg;
	logic return_from_exception, slow, mask_load, mask_value;
	mic_pkg::mic_grant_type grant_reg;
	logic wake_reg, seq_busy_reg, stack_write_reg, mask_set_reg, vector_fetch_reg;
	int error_cnt, check_count;
	mic_core #(.PERIPH_COUNT(26)) DUT (
		.clock(clock),
		.rst(rst),
		.nonmask_pin(nonmask_pin),
		.ext_request_n(ext_request_n),
		.key_sense_input_n(key_sense_input_n),
		.cfg(cfg),
		.periph_req(periph_req),
		.periph_enable(periph_enable),
		.global_mask(global_mask),
		.hw_standby(hw_standby),
		.sw_standby(sw_standby),
		.instr_done(instr_done),
		.cpu_pc(cpu_pc),
		.condition_code_byte(condition_code_byte),
		.return_from_exception(return_from_exception),
		.stack_word(stack_word),
		.grant_reg(grant_reg),
		.wake_reg(wake_reg),
		.seq_busy_reg(seq_busy_reg),
		.stack_write_reg(stack_write_reg),
		.stack_data_reg(stack_data_reg),
		.mask_set_reg(mask_set_reg),
		.vector_fetch_reg(vector_fetch_reg),
		.vector_addr_reg(vector_addr_reg),
		.restored_ccr_reg(restored_ccr_reg)
	);
	mic_cpu_model cpu (
		.clock(clock),
		.rst(rst),
		.mask_set_reg(mask_set_reg),
		.instr_done(instr_done),
		.global_mask(global_mask),
		.slow(slow),
		.mask_load(mask_load),
		.mask_value(mask_value)
	);
	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Inputs move 1 ns after the edge
	task automatic step();
		@(posedge clock);
		#1;
	endtask : step
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Bounded wait for a given vector on the grant
	task automatic wait_vec(input logic [5:0] exp, input int lim, input string name);
		int n;
		n = 0;
		while (!(grant_reg.valid === 1'b1 && grant_reg.vector === exp) && n < lim) begin
			step();
			n++;
		end
		check(name, {9'h000, grant_reg.valid, grant_reg.vector}, {10'h001, exp});
	endtask : wait_vec
	// No grant after a settling span
	task automatic quiet(input int cyc, input string name);
		repeat (cyc) step();
		check(name, {15'h0000, grant_reg.valid}, 16'h0000);
	endtask : quiet
	// Bounded wait for a push (0) or a fetch (1)
	task automatic wait_seq(input bit fetch, input int lim);
		int n;
		n = 0;
		while ((fetch ? vector_fetch_reg : stack_write_reg) !== 1'b1 && n < lim) begin
			step();
			n++;
		end
		check("seq_step", {15'h0000, fetch ? vector_fetch_reg : stack_write_reg}, 16'h0001);
	endtask : wait_seq
	task automatic set_mask(input logic v);
		mask_load = 1'b1;
		mask_value = v;
		step();
		mask_load = 1'b0;
	endtask : set_mask
	// Edge line 0, full sequence, then return
	task automatic edge_sequence();
		cfg.sense_select_reg[0] = 1'b1;
		cfg.request_enable_reg[0] = 1'b1;
		ext_request_n[0] = 1'b0;
		wait_vec(6'h04, 12, "edge_grant");
		wait_seq(1'b0, 4);
		check("pc_push", stack_data_reg, 16'h1234);
		step();
		check("ccr_push", stack_data_reg, 16'hC5C5);
		wait_seq(1'b1, 4);
		check("vec_addr", vector_addr_reg, 16'h0008);
		check("mask_on", {15'h0000, global_mask}, 16'h0001);
		set_mask(1'b0);
		quiet(10, "edge_once");
		stack_word = 16'hA53C;
		return_from_exception = 1'b1;
		step();
		return_from_exception = 1'b0;
		check("restore", {8'h00, restored_ccr_reg}, 16'h00A5);
		ext_request_n[0] = 1'b1;
	endtask : edge_sequence
	// Levels held under mask, nonmask wins, then priority order
	task automatic masked_priority();
		slow = 1'b1;
		set_mask(1'b1);
		cfg.sense_select_reg = 8'hB8;
		cfg.request_enable_reg = 8'hBF;
		ext_request_n = 3'b000;
		sw_standby = 1'b1;
		quiet(12, "masked_hold");
		check("wake", {15'h0000, wake_reg}, 16'h0001);
		sw_standby = 1'b0;
		nonmask_pin = 1'b0;
		wait_vec(mic_pkg::VEC_NONMASK, 12, "nonmask");
		slow = 1'b0;
		wait_seq(1'b1, 8);
		check("nm_addr", vector_addr_reg, 16'h0006);
		slow = 1'b1;
		set_mask(1'b0);
		wait_vec(6'h04, 6, "line0_first");
		ext_request_n = 3'b001;
		wait_vec(6'h05, 12, "line1_next");
		ext_request_n = 3'b011;
		wait_vec(6'h06, 12, "line2_last");
		ext_request_n = 3'b111;
		quiet(12, "levels_gone");
	endtask : masked_priority
	// Rising-edge select and hardware standby block
	task automatic nonmask_edges();
		cfg.nonmask_edge_select = 1'b1;
		hw_standby = 1'b1;
		nonmask_pin = 1'b1;
		quiet(12, "hw_block");
		hw_standby = 1'b0;
		nonmask_pin = 1'b0;
		quiet(12, "wrong_edge");
		nonmask_pin = 1'b1;
		wait_vec(mic_pkg::VEC_NONMASK, 12, "rising");
		slow = 1'b0;
		wait_seq(1'b1, 8);
		slow = 1'b1;
		set_mask(1'b0);
	endtask : nonmask_edges
	// Key line, then peripheral vectors and gating
	task automatic key_and_periph();
		int pidx [4] = '{0, 19, 20, 25};
		logic [5:0] pvec [4] = '{6'h11, 6'h24, 6'h2C, 6'h31};
		cfg.request_enable_reg[6] = 1'b1;
		key_sense_input_n = 8'hF7;
		quiet(12, "key_masked");
		cfg.key_mask_bits = 8'hF7;
		wait_vec(mic_pkg::VEC_EXT6, 12, "key_open");
		key_sense_input_n = 8'hFF;
		quiet(12, "key_gone");
		periph_req = 26'h0000001;
		quiet(3, "periph_off");
		periph_enable = '1;
		for (int i = 0; i < 4; i++) begin
			periph_req = 26'h1 << pidx[i];
			wait_vec(pvec[i], 1, "periph");
		end
		periph_req = 26'h2000001;
		wait_vec(6'h11, 1, "periph_prio");
		set_mask(1'b1);
		slow = 1'b0;
		quiet(3, "periph_masked");
		check("no_take", {15'h0000, seq_busy_reg}, 16'h0000);
		slow = 1'b1;
		set_mask(1'b0);
		wait_vec(6'h11, 2, "periph_back");
		periph_req = '0;
	endtask : key_and_periph
	task automatic stop_test();
		if (error_cnt == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test
	// Main sequence
	initial begin
		error_cnt = 0;
		check_count = 0;
		rst = 1'b1;
		nonmask_pin = 1'b1;
		ext_request_n = 3'h7;
		key_sense_input_n = 8'hFF;
		cfg = '{1'b0, 8'hB8, 8'hB8, 8'hFF};
		periph_req = '0;
		periph_enable = '0;
		{hw_standby, sw_standby, return_from_exception} = 3'h0;
		{slow, mask_load, mask_value} = 3'h0;
		cpu_pc = 16'h1234;
		condition_code_byte = 8'hC5;
		stack_word = 16'h0000;
		repeat (2) @(posedge clock);
		#1 rst = 1'b0;
		step();
		edge_sequence();
		masked_priority();
		nonmask_edges();
		key_and_periph();
		stop_test();
	end
	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		stop_test();
	end
endmodule : tb_top
